// file: bench/cpr_profiling_capability_report_bench.sv
// self-checking bench for the profiling capability report
// assumes an answer two edges after the take and a one-edge configuration write
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errTotal++; \
	$display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module cpr_profiling_capability_report_bench
	import cpr_pkg::*;
;
	logic                     clk, rst_n, queryValid, queryReady, resultValid, resultHit, cfgWrite;
	logic [31:0]              queryLeaf, resultCapability, cfgWdata, cfgRdata;
	logic [CPR_EXT_WIDTH-1:0] extMask;
	cpr_avail_s               resultAvail;
	cpr_layout_s              resultLayout;
	int                       errTotal, compares, cycles, cfgModel;
	integer                   seed;
	int                       modelQ[$];

	cpr_profiling_capability_report DUT (.clk(clk), .rst_n(rst_n), .queryValid(queryValid),
		.queryLeaf(queryLeaf), .queryReady(queryReady), .resultValid(resultValid), .resultHit(resultHit),
		.resultAvail(resultAvail), .resultLayout(resultLayout), .resultCapability(resultCapability),
		.extFeatureEnableMask(extMask), .cfgWrite(cfgWrite), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic stopTest();
		$display("compares %0d errors %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stopTest

	// hang guard: the whole run needs a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			errTotal++;
			stopTest();
		end
	end

	// one query; a write may land on the take edge, and the query must still see the old value
	task automatic query(input logic [31:0] leaf, input logic doWrite, input logic [31:0] wdata, input logic poke);
		logic [31:0] expAvail, expLayout, expCap;
		logic        hit;
		while (queryReady !== 1'b1) @(posedge clk) #1;
		hit = (leaf == CPR_LEAF);
		// the model queues its answer before the take and the check pops it once the result stands
		modelQ.push_back(hit ? int'((32'(cfgModel) & 32'hE000_007E) | 32'(extMask[62])) : 0);
		modelQ.push_back(hit ? int'(32'h5006_2010) : 0);
		modelQ.push_back(hit ? int'(32'hE000_007F) : 0);
		queryValid = 1'b1;
		queryLeaf = leaf;
		cfgWrite = doWrite;
		cfgWdata = wdata;
		@(posedge clk) #1;
		if (doWrite) cfgModel = wdata & 32'hE000_007E;
		cfgWrite = 1'b0;
		queryValid = poke;
		queryLeaf = $random(seed);
		extMask = {$random(seed), $random(seed)};
		`CHK(queryReady, 1'b0)
		`CHK(resultValid, 1'b0)
		`CHK(cfgRdata, 32'(cfgModel))
		@(posedge clk) #1;
		expAvail = 32'(modelQ.pop_front());
		expLayout = 32'(modelQ.pop_front());
		expCap = 32'(modelQ.pop_front());
		`CHK(resultValid, 1'b1)
		`CHK(resultHit, hit)
		`CHK(resultAvail, expAvail)
		`CHK(resultLayout, expLayout)
		`CHK(resultCapability, expCap)
		`CHK(32'(resultAvail) & resultCapability, expAvail)
	endtask : query

	initial begin
		seed = 32'h64F87E70;
		rst_n = 1'b0;
		queryValid = 1'b0;
		queryLeaf = 32'h0;
		cfgWrite = 1'b0;
		cfgWdata = 32'h0;
		extMask = '0;
		cfgModel = 0;
		errTotal = 0;
		compares = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK(cfgRdata, 32'h0)
		extMask[62] = 1'b1;
		query(CPR_LEAF, 1'b1, 32'hFFFF_FFFF, 1'b0);
		query(CPR_LEAF, 1'b0, 32'h0, 1'b1);
		for (int b = 0; b < 32; b++) query(CPR_LEAF, 1'b1, 32'h1 << b, 1'b0);
		for (int i = 0; i < 40; i++) query(($random(seed) & 3) ? CPR_LEAF : $random(seed), 1'($random(seed)),
			$random(seed), 1'($random(seed)));
		query(32'h8000_001B, 1'b0, 32'h0, 1'b0);
		repeat (4) @(posedge clk);
		stopTest();
	end
endmodule : cpr_profiling_capability_report_bench

// file: bench/cpr_profiling_capability_report_chk.sv
// assertion checker for the profiling capability report
// assumes it is bound onto the report top and sees only its ports
`timescale 1ns/1ps
module cpr_profiling_capability_report_chk
	import cpr_pkg::*;
(
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rst_n,
	// query side
	input wire logic                     queryValid,
	input wire logic [31:0]              queryLeaf,
	input wire logic                     queryReady,
	input wire logic                     resultValid,
	input wire logic                     resultHit,
	input wire cpr_avail_s               resultAvail,
	input wire cpr_layout_s              resultLayout,
	input wire logic [31:0]              resultCapability,
	// register side
	input wire logic [CPR_EXT_WIDTH-1:0] extFeatureEnableMask,
	input wire logic                     cfgWrite,
	input wire logic [31:0]              cfgWdata,
	input wire logic [31:0]              cfgRdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire take = queryValid && queryReady;
	wire done = resultValid && resultHit;

	chk_usable_copy: assert property (take && queryLeaf == CPR_LEAF |-> ##2 done &&
		resultAvail.profilingUsable == $past(extFeatureEnableMask[CPR_EXT_ENABLE_BIT], 2))
		else $error("usable flag not the enable bit at take");
	chk_feature_copy: assert property (take && queryLeaf == CPR_LEAF |-> ##2
		(resultAvail & 32'hFFFF_FFFE) == ($past(cfgRdata, 2) & CPR_FEATURE_MASK))
		else $error("feature flags not the configuration snapshot");
	chk_subset_cap: assert property (resultValid |-> (resultAvail[31:1] & ~resultCapability[31:1]) == 31'h0)
		else $error("available feature missing from support word");
	chk_cap_word: assert property (done |-> resultCapability == CPR_HW_CAPABILITY)
		else $error("support word wrong");
	chk_rsvd_zero: assert property (resultAvail.reserved == 22'h0 && cfgRdata[28:7] == 22'h0)
		else $error("reserved bits set");
	chk_layout_sizes: assert property (done |-> resultLayout.recordBytes == 8'h20 &&
		resultLayout.maxEventId != 8'hFF && resultLayout.eventAreaOffset[2:0] == 3'h0)
		else $error("layout field wrong");
	chk_cb_size: assert property (done |->
		resultLayout.controlBlockQwords >= (resultLayout.eventAreaOffset >> 3) + resultLayout.maxEventId)
		else $error("control block too small");
	chk_cfg_mask: assert property (cfgWrite |=> cfgRdata == ($past(cfgWdata) & CPR_FEATURE_MASK))
		else $error("configuration write not masked");
	chk_busy_gap: assert property (take |=> !queryReady [*2] ##1 queryReady)
		else $error("query gap wrong");
endmodule : cpr_profiling_capability_report_chk

bind cpr_profiling_capability_report cpr_profiling_capability_report_chk u_chk (.clk, .rst_n, .queryValid,
	.queryLeaf, .queryReady, .resultValid, .resultHit, .resultAvail, .resultLayout, .resultCapability,
	.extFeatureEnableMask, .cfgWrite, .cfgWdata, .cfgRdata);

// file: core/cpr_avail_word.sv
// builds the first result word from the enable bit and the configuration register
// assumes its inputs are stable snapshots held by the caller
`timescale 1ns/1ps
module cpr_avail_word
	import cpr_pkg::*;
(
	// sources
	input  wire logic        extEnableBit,
	input  wire logic [31:0] cfgBits,
	input  wire logic [31:0] hwCapability,
	// result
	output cpr_avail_s       availWord
);

	logic [31:0] rawWord;

	// bit 0 is a straight copy, never masked by support
	assign rawWord[CPR_USABLE_BIT] = extEnableBit; // [R1]

	genvar gi;
	generate
		for (gi = 1; gi < 32; gi++) begin : g_bit
			// a feature shows only if configured, supported and defined
			assign rawWord[gi] = cfgBits[gi] & hwCapability[gi] & CPR_FEATURE_MASK[gi]; // [R2] [R3] [R6]
		end
	endgenerate

	// event flags 1..6 and mode flags 29..31 land at their struct positions
	assign availWord = cpr_avail_s'(rawWord); // [R4] [R5]

endmodule : cpr_avail_word

// file: core/cpr_layout_word.sv
// builds the second result word from the fixed layout figures
// assumes nothing outside; the word is constant
`timescale 1ns/1ps
module cpr_layout_word
	import cpr_pkg::*;
(
	// result
	output cpr_layout_s layoutWord
);

	logic [7:0] offsetAligned;
	logic [7:0] maxId;
	logic [7:0] cbFloor;

	// offset forced to a quadword boundary
	assign offsetAligned = CPR_EVENT_OFFSET & CPR_OFFSET_ALIGN; // [R10]
	// the user-inserted identifier is never counted as the maximum
	assign maxId         = (CPR_MAX_EVENT_ID == CPR_USER_EVENT_ID) ? 8'(CPR_MAX_EVENT_ID - 8'h01)
	                                                               : CPR_MAX_EVENT_ID; // [R9]
	assign cbFloor       = 8'((offsetAligned >> CPR_QWORD_SHIFT) + maxId);

	// an implementation may want more than the floor, never less
	assign layoutWord.controlBlockQwords = (CPR_CB_QWORDS_IMPL > cbFloor) ? CPR_CB_QWORDS_IMPL
	                                                                     : cbFloor; // [R7]
	assign layoutWord.recordBytes        = CPR_RECORD_BYTES; // [R8]
	assign layoutWord.maxEventId         = maxId; // [R9]
	assign layoutWord.eventAreaOffset    = offsetAligned; // [R10]

endmodule : cpr_layout_word

// file: core/cpr_pkg.sv
// constants, field layouts and carrier types for the profiling capability report
// assumes one core clock; every value here is static for the life of the part
package cpr_pkg;

	// query leaf that selects this report
	localparam logic [31:0] CPR_LEAF             = 32'h8000_001C;

	// position of the profiling enable bit in the extended-feature enable register
	localparam int          CPR_EXT_ENABLE_BIT   = 62;
	localparam int          CPR_EXT_WIDTH        = 64;

	// first result word field positions
	localparam int          CPR_USABLE_BIT       = 0;
	localparam int          CPR_VALUE_INSERT_BIT = 1;
	localparam int          CPR_INSTR_BIT        = 2;
	localparam int          CPR_BRANCH_BIT       = 3;
	localparam int          CPR_DCACHE_BIT       = 4;
	localparam int          CPR_CORE_CLK_BIT     = 5;
	localparam int          CPR_REF_CLK_BIT      = 6;
	localparam int          CPR_RSVD_LO_BIT      = 7;
	localparam int          CPR_RSVD_HI_BIT      = 28;
	localparam int          CPR_CONT_BIT         = 29;
	localparam int          CPR_TSC_BIT          = 30;
	localparam int          CPR_IRQ_BIT          = 31;

	// feature bits that may ever be reported (bit 0 comes from the enable register)
	localparam logic [31:0] CPR_FEATURE_MASK     = 32'hE000_007E;

	// hardware support word, same positions as the first result word
	localparam logic [31:0] CPR_HW_CAPABILITY    = 32'hE000_007F;

	// configuration register reset value: nothing offered to applications
	localparam logic [31:0] CPR_CFG_RESET        = 32'h0000_0000;

	// layout figures of the control block and ring buffer
	localparam logic [7:0]  CPR_RECORD_BYTES     = 8'h20;
	localparam logic [7:0]  CPR_MAX_EVENT_ID     = 8'h06;
	localparam logic [7:0]  CPR_USER_EVENT_ID    = 8'hFF;
	localparam logic [7:0]  CPR_EVENT_OFFSET     = 8'h50;
	localparam logic [7:0]  CPR_CB_QWORDS_IMPL   = 8'h10;
	localparam logic [7:0]  CPR_OFFSET_ALIGN     = 8'hF8;
	localparam int          CPR_QWORD_SHIFT      = 3;

	// result word reset value
	localparam logic [31:0] CPR_WORD_RESET       = 32'h0000_0000;

	typedef struct packed {
		logic        thresholdIrqFlag;
		logic        timestampInRecordFlag;
		logic        continuousSamplingFlag;
		logic [21:0] reserved;
		logic        refClkEventFlag;
		logic        coreClkEventFlag;
		logic        dcacheMissEventFlag;
		logic        branchRetiredEventFlag;
		logic        instrRetiredEventFlag;
		logic        valueInsertEventFlag;
		logic        profilingUsable;
	} cpr_avail_s;

	typedef struct packed {
		logic [7:0] eventAreaOffset;
		logic [7:0] maxEventId;
		logic [7:0] recordBytes;
		logic [7:0] controlBlockQwords;
	} cpr_layout_s;

	typedef enum logic [1:0] {
		CPR_ST_IDLE,
		CPR_ST_COMPOSE,
		CPR_ST_RESPOND
	} cpr_state_e;

endpackage : cpr_pkg

// file: core/cpr_profiling_capability_report.sv
// top of the profiling capability report: query leaf answer and configuration register
// assumes the core presents one query at a time and owns the extended-feature enable register
//
// What this block does
// [R1] Bit 0 of the first word copies bit 62 of the extended-feature enable register.
// [R2] Bits 31:1 of the first word come from the profiling configuration register.
// [R3] No feature shows as available unless it is also set in the hardware support word.
// [R4] Bits 1 to 6 of the first word flag the events with identifiers 1 to 6.
// [R5] Bits 29, 30 and 31 flag continuous sampling, timestamp in records and threshold interrupt.
// [R6] Bits 28:7 of the first word read as zero.
// [R7] Bits 7:0 of the second word give the control block size, at least offset/8 plus the maximum identifier.
// [R8] Bits 15:8 of the second word give the event record size, 32 bytes.
// [R9] Bits 23:16 of the second word give the highest event identifier, never the user value 255.
// [R10] Bits 31:24 of the second word give the event area offset, a multiple of 8.
// [R11] A hypervisor pooling processors reports the common subset of these values; this block has no pooling logic and always reports its own fixed values.
// [R12] Applications use only the first word; the operating system decides from the support word.
// [R13] The support word uses the same bit positions as the first word but flags hardware support.
`timescale 1ns/1ps
module cpr_profiling_capability_report
	import cpr_pkg::*;
(
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,

	// query request
	input  wire logic                     queryValid,
	input  wire logic [31:0]              queryLeaf,
	output logic                          queryReady,

	// query answer
	output logic                          resultValid,
	output logic                          resultHit,
	output cpr_avail_s                    resultAvail,
	output cpr_layout_s                   resultLayout,
	output logic [31:0]                   resultCapability,

	// extended-feature enable register, owned by the core
	input  wire logic [CPR_EXT_WIDTH-1:0] extFeatureEnableMask,

	// profiling configuration register access
	input  wire logic                     cfgWrite,
	input  wire logic [31:0]              cfgWdata,
	output logic [31:0]                   cfgRdata
);

	// state
	cpr_state_e  state_r;
	cpr_state_e  state_nxt;

	// configuration register
	logic [31:0] cfg_r;
	logic [31:0] cfg_nxt;

	// snapshot taken when a query is accepted
	logic        snapEnable_r;
	logic        snapEnable_nxt;
	logic [31:0] snapCfg_r;
	logic [31:0] snapCfg_nxt;
	logic        snapHit_r;
	logic        snapHit_nxt;

	// result registers
	logic [31:0] availWord_r;
	logic [31:0] availWord_nxt;
	logic [31:0] layoutWord_r;
	logic [31:0] layoutWord_nxt;
	logic [31:0] capWord_r;
	logic [31:0] capWord_nxt;
	logic        resultValid_r;
	logic        resultValid_nxt;
	logic        resultHit_r;
	logic        resultHit_nxt;

	// decode
	wire logic        queryTake;
	wire logic        leafMatch;
	wire logic        composeDone;
	wire logic [31:0] cfgMasked;
	wire logic        enableBit;

	// composed words
	cpr_avail_s  availComposed;
	cpr_layout_s layoutComposed;

	assign queryReady  = (state_r == CPR_ST_IDLE);
	assign queryTake   = queryValid & queryReady;
	assign leafMatch   = (queryLeaf == CPR_LEAF);
	assign composeDone = (state_r == CPR_ST_COMPOSE);
	assign enableBit   = extFeatureEnableMask[CPR_EXT_ENABLE_BIT]; // [R1]

	// software can never offer more than the hardware supports, so the register drops the rest
	assign cfgMasked   = cfgWdata & CPR_HW_CAPABILITY & CPR_FEATURE_MASK; // [R3]

	// word builders

	cpr_avail_word u_avail (
		.extEnableBit (snapEnable_r),
		.cfgBits      (snapCfg_r),
		.hwCapability (CPR_HW_CAPABILITY),
		.availWord    (availComposed)
	);

	cpr_layout_word u_layout (
		.layoutWord (layoutComposed)
	);

	// next-state logic

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			CPR_ST_IDLE: begin
				if (queryTake) begin
					state_nxt = CPR_ST_COMPOSE;
				end
			end
			CPR_ST_COMPOSE: begin
				state_nxt = CPR_ST_RESPOND;
			end
			CPR_ST_RESPOND: begin
				state_nxt = CPR_ST_IDLE;
			end
			default: begin
				state_nxt = CPR_ST_IDLE;
			end
		endcase
	end

	// a write landing in the same cycle as a query is seen by the next query only,
	// because the snapshot takes the value held before the edge
	assign cfg_nxt        = cfgWrite ? cfgMasked : cfg_r; // [R2]

	assign snapEnable_nxt = queryTake ? enableBit : snapEnable_r; // [R1]
	assign snapCfg_nxt    = queryTake ? cfg_r : snapCfg_r; // [R2]
	assign snapHit_nxt    = queryTake ? leafMatch : snapHit_r;

	// an unknown leaf answers with all-zero words rather than stale ones
	assign availWord_nxt  = composeDone ? (snapHit_r ? 32'(availComposed) : CPR_WORD_RESET)
	                                    : availWord_r; // [R4] [R5] [R6]
	assign layoutWord_nxt = composeDone ? (snapHit_r ? 32'(layoutComposed) : CPR_WORD_RESET)
	                                    : layoutWord_r; // [R7] [R8] [R9] [R10]
	assign capWord_nxt    = composeDone ? (snapHit_r ? CPR_HW_CAPABILITY : CPR_WORD_RESET)
	                                    : capWord_r; // [R13]

	assign resultValid_nxt = composeDone;
	assign resultHit_nxt   = composeDone ? snapHit_r : resultHit_r;

	// registers

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CPR_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= CPR_CFG_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snapEnable_r <= 1'b0;
		end else begin
			snapEnable_r <= snapEnable_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snapCfg_r <= CPR_CFG_RESET;
		end else begin
			snapCfg_r <= snapCfg_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snapHit_r <= 1'b0;
		end else begin
			snapHit_r <= snapHit_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			availWord_r <= CPR_WORD_RESET;
		end else begin
			availWord_r <= availWord_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			layoutWord_r <= CPR_WORD_RESET;
		end else begin
			layoutWord_r <= layoutWord_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capWord_r <= CPR_WORD_RESET;
		end else begin
			capWord_r <= capWord_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resultValid_r <= 1'b0;
		end else begin
			resultValid_r <= resultValid_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resultHit_r <= 1'b0;
		end else begin
			resultHit_r <= resultHit_nxt;
		end
	end

	// outputs

	// words hold from one answer to the next so a slow reader may sample late
	assign resultValid      = resultValid_r;
	assign resultHit        = resultHit_r;
	assign resultAvail      = cpr_avail_s'(availWord_r);
	assign resultLayout     = cpr_layout_s'(layoutWord_r);
	assign resultCapability = capWord_r; // [R13]
	assign cfgRdata         = cfg_r;

endmodule : cpr_profiling_capability_report
